// file: core/pds_sequencer.sv
// Behaviour
// R01: after power-down request, keep analog running 32 cycles, then switch it off.
// R02: firmware stops the core within the grace interval.
// R03: firmware sets wake routing before requesting power-down.
// R04: leave power-down when user pins, smart card or keypad interrupt asserts.
// R05: OR the three wake sources, delay, then present on interrupt line zero.
// R06: on wake, restore power to all sections and restart clocks; power_save_eff stays all ones until the wake delay expires.
// R07: after clocks restart, count 512 cycles before releasing wake interrupt.
// R08: assert line zero interrupt only once the delay counter expires.
// R09: reading wake interrupt control clears the wake routing bit.
// R10: power-down request overrides every individual power-saving control bit.
// R11: wake routing is bit 7; it redirects the three sources to line zero.
// R12: delay counter restarts per wake, stays clear while asleep without wake.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module pds_sequencer import pds_pkg::*; #(
  parameter int GRACE_CYCLES = PDS_GRACE_CYCLES,
  parameter int WAKE_DELAY_CYCLES = PDS_WAKE_DELAY_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic user_interrupt_pins_irq,
  input wire logic smart_card_irq,
  input wire logic keypad_irq,
  input wire logic clocks_running,
  output logic analog_enable,
  output logic clock_restart,
  output logic [PDS_POWER_SAVE_BITS-1:0] power_save_eff,
  output logic ext_irq_line_zero,
  output logic user_pins_to_line_zero,
  output logic smart_card_irq_out,
  output logic keypad_irq_out,
  output logic power_down_active
);
  typedef struct packed {
    pds_state_t state;
    logic wake_route_enable;
    logic kp_irq_en;
    logic kp_irq_flag;
    logic power_down_request;
    logic [PDS_POWER_SAVE_BITS-1:0] power_save;
    logic [7:0] rdata;
    logic wake_irq;
  } pds_st_t;

  pds_st_t st_q;
  pds_st_t st_d;
  logic [2:0] src_sync;
  logic wake_any;
  logic grace_done;
  logic delay_done;
  logic grace_clear;
  logic delay_clear;
  logic delay_run;
  logic hit_wake;
  logic hit_misc;

  if (GRACE_CYCLES < 1 || WAKE_DELAY_CYCLES < 1) begin : g_bad_counts
    $error("pds_sequencer: cycle counts must be at least 1");
  end

  // interrupt sources come from other blocks and pins; resynchronise all three
  pds_sync #(
    .WIDTH(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({keypad_irq, smart_card_irq, user_interrupt_pins_irq}),
    .sync_out(src_sync)
  );

  assign wake_any = |src_sync; // R05

  // counting starts with the stored request so analog drops GRACE_CYCLES+1 edges after the write
  assign grace_clear = !((st_q.state == PDS_GRACE) || (st_q.state == PDS_RUN && st_q.power_down_request)); // R01
  pds_counter #(
    .TERMINAL(GRACE_CYCLES)
  ) u_grace (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(grace_clear),
    .run(1'b1),
    .done(grace_done)
  );

  // cleared outside the wake phase so each new wake starts from zero
  assign delay_clear = (st_q.state != PDS_WAKE); // R12
  assign delay_run = clocks_running; // R07
  pds_counter #(
    .TERMINAL(WAKE_DELAY_CYCLES)
  ) u_delay (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(delay_clear),
    .run(delay_run),
    .done(delay_done)
  );

  assign hit_wake = (reg_addr == PDS_ADDR_WAKE_CTL);
  assign hit_misc = (reg_addr == PDS_ADDR_MISC_PWR);

  always_comb begin
    st_d = st_q;
    st_d.rdata = 8'h00;
    st_d.wake_irq = 1'b0;

    if (reg_wr && hit_wake) begin
      st_d.wake_route_enable = reg_wdata[PDS_WAKE_ROUTE_BIT]; // R11
      st_d.kp_irq_en = reg_wdata[PDS_KP_IRQ_EN_BIT];
      st_d.kp_irq_flag = reg_wdata[PDS_KP_IRQ_FLAG_BIT];
    end
    if (reg_wr && hit_misc) begin
      st_d.power_down_request = reg_wdata[PDS_PWR_DOWN_BIT];
      st_d.power_save = reg_wdata[PDS_POWER_SAVE_BITS-1:0];
    end

    // keypad flag: hardware set wins over a software clear in the same cycle
    if (src_sync[2]) begin
      st_d.kp_irq_flag = 1'b1;
    end

    if (reg_rd && hit_wake) begin
      st_d.rdata[PDS_WAKE_ROUTE_BIT] = st_q.wake_route_enable;
      st_d.rdata[PDS_KP_IRQ_EN_BIT] = st_q.kp_irq_en;
      st_d.rdata[PDS_KP_IRQ_FLAG_BIT] = st_q.kp_irq_flag;
      st_d.wake_route_enable = 1'b0; // R09
    end
    if (reg_rd && hit_misc) begin
      st_d.rdata[PDS_PWR_DOWN_BIT] = st_q.power_down_request;
      st_d.rdata[PDS_POWER_SAVE_BITS-1:0] = st_q.power_save;
    end

    unique case (st_q.state)
      PDS_RUN: begin
        if (st_q.power_down_request) begin
          st_d.state = PDS_GRACE;
        end
      end
      PDS_GRACE: begin
        // grace lets firmware stop the core before the analog goes away
        if (grace_done) begin
          st_d.state = PDS_DOWN; // R01 R02
        end
      end
      PDS_DOWN: begin
        if (wake_any) begin
          st_d.state = PDS_WAKE; // R04
        end
      end
      PDS_WAKE: begin
        if (delay_done) begin
          st_d.state = PDS_RUN;
          st_d.power_down_request = 1'b0;
          st_d.wake_irq = st_q.wake_route_enable; // R08
        end
      end
      default: begin
        st_d.state = PDS_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q.state <= PDS_RUN;
      st_q.wake_route_enable <= PDS_WAKE_CTL_RESET[PDS_WAKE_ROUTE_BIT];
      st_q.kp_irq_en <= PDS_WAKE_CTL_RESET[PDS_KP_IRQ_EN_BIT];
      st_q.kp_irq_flag <= PDS_WAKE_CTL_RESET[PDS_KP_IRQ_FLAG_BIT];
      st_q.power_down_request <= PDS_MISC_PWR_RESET[PDS_PWR_DOWN_BIT];
      st_q.power_save <= PDS_MISC_PWR_RESET[PDS_POWER_SAVE_BITS-1:0];
      st_q.rdata <= 8'h00;
      st_q.wake_irq <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  // analog stays on in run and grace; off while down; back on from wake
  assign analog_enable = (st_q.state != PDS_DOWN); // R01 R06
  assign clock_restart = (st_q.state == PDS_WAKE); // R06
  assign power_down_active = st_q.power_down_request;
  assign power_save_eff = st_q.power_down_request ? {PDS_POWER_SAVE_BITS{1'b1}} : st_q.power_save; // R10
  // routing steers all three sources away from their own lines while set
  assign user_pins_to_line_zero = st_q.wake_route_enable ? 1'b0 : src_sync[0]; // R11
  assign smart_card_irq_out = st_q.wake_route_enable ? 1'b0 : src_sync[1]; // R11
  assign keypad_irq_out = st_q.wake_route_enable ? 1'b0 : (src_sync[2] & st_q.kp_irq_en);
  assign ext_irq_line_zero = st_q.wake_irq | user_pins_to_line_zero; // R05 R08
endmodule // pds_sequencer

// file: core/pds_pkg.sv
package pds_pkg;
  localparam logic [15:0] PDS_ADDR_WAKE_CTL = 16'hFF94;
  localparam logic [15:0] PDS_ADDR_MISC_PWR = 16'hFFF1;
  localparam logic [7:0] PDS_WAKE_CTL_RESET = 8'h00;
  localparam logic [7:0] PDS_MISC_PWR_RESET = 8'h00;
  localparam int PDS_WAKE_ROUTE_BIT = 7;
  localparam int PDS_KP_IRQ_EN_BIT = 1;
  localparam int PDS_KP_IRQ_FLAG_BIT = 0;
  localparam int PDS_PWR_DOWN_BIT = 7;
  localparam int PDS_GRACE_CYCLES = 32;
  localparam int PDS_WAKE_DELAY_CYCLES = 512;
  localparam int PDS_POWER_SAVE_BITS = 7;

  typedef enum logic [3:0] {
    PDS_RUN = 4'b0001,
    PDS_GRACE = 4'b0010,
    PDS_DOWN = 4'b0100,
    PDS_WAKE = 4'b1000
  } pds_state_t;
endpackage

// file: core/pds_sync.sv
`timescale 1ns/1ps
module pds_sync import pds_pkg::*; #(
  parameter int WIDTH = 3
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } pds_sync_st_t;

  pds_sync_st_t st_q;
  pds_sync_st_t st_d;

  if (WIDTH < 1) begin : g_bad_width
    $error("pds_sync: WIDTH must be at least 1");
  end

  always_comb begin
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.sync;
endmodule // pds_sync

// file: core/pds_counter.sv
`timescale 1ns/1ps
module pds_counter import pds_pkg::*; #(
  parameter int TERMINAL = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic run,
  output logic done
);
  localparam int CW = $clog2(TERMINAL + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic done;
  } pds_cnt_st_t;

  pds_cnt_st_t st_q;
  pds_cnt_st_t st_d;

  if (TERMINAL < 1) begin : g_bad_terminal
    $error("pds_counter: TERMINAL must be at least 1");
  end

  // done rises on the edge that completes TERMINAL counted cycles
  always_comb begin
    st_d = st_q;
    if (clear) begin
      st_d.count = '0;
      st_d.done = 1'b0;
    end else if (run && !st_q.done) begin
      st_d.count = st_q.count + CW'(1);
      st_d.done = (st_q.count == CW'(TERMINAL - 1));
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign done = st_q.done;
endmodule // pds_counter

// file: tb/pds_sequencer_monitor.sv
`timescale 1ns/1ps
module pds_sequencer_monitor import pds_pkg::*; #(
  parameter int GRACE_CYCLES = PDS_GRACE_CYCLES,
  parameter int WAKE_DELAY_CYCLES = PDS_WAKE_DELAY_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic user_interrupt_pins_irq,
  input wire logic smart_card_irq,
  input wire logic keypad_irq,
  input wire logic clocks_running,
  input wire logic analog_enable,
  input wire logic clock_restart,
  input wire logic [PDS_POWER_SAVE_BITS-1:0] power_save_eff,
  input wire logic ext_irq_line_zero,
  input wire logic power_down_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [15:0] run_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) run_q <= 16'h0000;
    else run_q <= clock_restart ? run_q + 16'(clocks_running) : 16'h0000;
  end
  grace_exact_a: assert property ($fell(analog_enable) |->
    $past(power_down_active, GRACE_CYCLES + 1) && !$past(power_down_active, GRACE_CYCLES + 2)) else $error("grace");
  power_back_a: assert property (clock_restart |-> analog_enable) else $error("power");
  wake_exit_a: assert property (!analog_enable && (user_interrupt_pins_irq || smart_card_irq || keypad_irq)
    |-> ##[1:4] clock_restart) else $error("wake");
  delay_len_a: assert property ($fell(clock_restart) |->
    run_q >= WAKE_DELAY_CYCLES && run_q <= WAKE_DELAY_CYCLES + 1) else $error("delay");
  irq_gated_a: assert property (clock_restart && ext_irq_line_zero |-> run_q >= WAKE_DELAY_CYCLES) else $error("irq");
  save_override_a: assert property (power_down_active |-> &power_save_eff) else $error("save");
  read_clear_a: assert property (reg_rd && reg_addr == PDS_ADDR_WAKE_CTL ##1 reg_rd &&
    reg_addr == PDS_ADDR_WAKE_CTL |=> !reg_rdata[PDS_WAKE_ROUTE_BIT]) else $error("clear");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("idle");
endmodule // pds_sequencer_monitor
bind pds_sequencer pds_sequencer_monitor #(.GRACE_CYCLES(GRACE_CYCLES), .WAKE_DELAY_CYCLES(WAKE_DELAY_CYCLES)) mon (
  .sys_clk, .rst, .reg_addr, .reg_rd, .reg_rdata, .user_interrupt_pins_irq, .smart_card_irq, .keypad_irq,
  .clocks_running, .analog_enable, .clock_restart, .power_save_eff, .ext_irq_line_zero, .power_down_active);

// file: tb/pds_src_model.sv
`timescale 1ns/1ps
module pds_src_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clock_restart,
  input wire logic [2:0] fire,
  input wire logic slow,
  output logic user_interrupt_pins_irq,
  output logic smart_card_irq,
  output logic keypad_irq,
  output logic clocks_running
);
  logic [3:0] lag_q;
  // slow mode mimics an oscillator that takes a while to settle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) lag_q <= 4'h0;
    else lag_q <= clock_restart ? lag_q + 4'(lag_q != 4'hF) : 4'h0;
  end
  assign clocks_running = clock_restart && (!slow || lag_q > 4'h5);
  assign {keypad_irq, smart_card_irq, user_interrupt_pins_irq} = fire;
endmodule // pds_src_model

// file: tb/power_down_wake_sequencer_tb.sv
`timescale 1ns/1ps
module power_down_wake_sequencer_tb import pds_pkg::*;;
  localparam int GC = 4;
  localparam int WD = 8;
  logic sys_clk, rst, reg_wr, reg_rd, slow, analog_enable, clock_restart, ext_irq_line_zero, power_down_active;
  logic user_interrupt_pins_irq, smart_card_irq, keypad_irq, clocks_running;
  logic user_pins_to_line_zero, smart_card_irq_out, keypad_irq_out;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, m;
  logic [2:0] fire;
  logic [PDS_POWER_SAVE_BITS-1:0] power_save_eff;
  int n_errors = 0;
  int num_checks = 0;
  int n;
  pds_sequencer #(.GRACE_CYCLES(GC), .WAKE_DELAY_CYCLES(WD)) DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .user_interrupt_pins_irq, .smart_card_irq, .keypad_irq, .clocks_running, .analog_enable,
    .clock_restart, .power_save_eff, .ext_irq_line_zero, .user_pins_to_line_zero, .smart_card_irq_out,
    .keypad_irq_out, .power_down_active);
  pds_src_model PM (.sys_clk, .rst, .clock_restart, .fire, .slow, .user_interrupt_pins_irq, .smart_card_irq,
    .keypad_irq, .clocks_running);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] exp_save(logic [7:0] v);
    return v[7] ? 16'h007F : {9'h000, v[6:0]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string s, logic [15:0] seen, logic [15:0] e);
    num_checks++;
    if (seen !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", s, e, seen);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", 16'(reg_rdata), 16'(e));
  endtask
  // sel 0 waits for analog off, sel 1 for the line-zero interrupt
  task automatic aw(int sel, output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end while (cnt < 99 && (sel ? ext_irq_line_zero !== 1'b1 : analog_enable !== 1'b0));
    if (cnt >= 99) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  initial begin
    void'($urandom(6086));
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, fire, slow} = {3'b100, 16'h0000, 8'h00, 3'b000, 1'b0};
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("reset", 16'({analog_enable, clock_restart, ext_irq_line_zero, power_down_active}), 16'h0008);
    rd(PDS_ADDR_WAKE_CTL, PDS_WAKE_CTL_RESET);
    rd(PDS_ADDR_MISC_PWR, PDS_MISC_PWR_RESET);
    wr(16'hFF00, 8'hFF);
    rd(16'hFF00, 8'h00);
    m = 8'($urandom()) & 8'h7F;
    wr(PDS_ADDR_MISC_PWR, m);
    rd(PDS_ADDR_MISC_PWR, m);
    chk("save", 16'(power_save_eff), exp_save(m));
    wr(PDS_ADDR_WAKE_CTL, 8'h82);
    rd(PDS_ADDR_WAKE_CTL, 8'h82);
    rd(PDS_ADDR_WAKE_CTL, 8'h02);
    fire <= 3'b111;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("route", 16'({user_pins_to_line_zero, smart_card_irq_out, keypad_irq_out, ext_irq_line_zero}), 16'h000F);
    wr(PDS_ADDR_WAKE_CTL, 8'h82);
    chk("route", 16'({user_pins_to_line_zero, smart_card_irq_out, keypad_irq_out, ext_irq_line_zero}), 16'h0000);
    rd(PDS_ADDR_WAKE_CTL, 8'h83);
    fire <= 3'b000;
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      wr(PDS_ADDR_WAKE_CTL, 8'h80);
      wr(PDS_ADDR_MISC_PWR, 8'h80 | m);
      chk("save", 16'(power_save_eff), exp_save(8'h80 | m));
      aw(0, n);
      chk("grace", 16'(n), 16'(GC + 1));
      repeat ($urandom_range(9)) @(posedge sys_clk);
      fire <= 3'b001 << (i % 3);
      aw(1, n);
      chk("delay", 16'(n), 16'(WD + 4 + (slow ? 6 : 0)));
      chk("analog", 16'(analog_enable), 16'h0001);
      @(posedge sys_clk);
      #1;
      chk("pulse", 16'(ext_irq_line_zero), 16'h0000);
      fire <= 3'b000;
    end
    report_and_stop();
  end
endmodule // power_down_wake_sequencer_tb
